// >>> hdl/sbr_pkg.sv
// Functional notes
// - Edge-select bit picks falling or rising edge
// - Handshake role bit resets to one, ready
// - Ready held low during configuration and reset
// - High-low-high pulse restarts first address latch
// - Role zero makes pin a wait output
// - Wrap bit confines burst to aligned group
// - Burst gives 4, 8, 16 or continuous words
// - Continuous burst crosses bank boundaries unterminated
// - Wrapped fixed bursts insert no wait cycles
// - Start offset gives wait at 16-word crossing
// - Continuous burst waits only once
// - Wrap ignored in continuous mode
// - Host writes reserved bits as zero
// - Synchronous reads supported; asynchronous mode only idles the burst engine
// - Address latched on third qualified edge
// - Third counted edge then latency, default seven
// - Latency field codes two to seven cycles
// - Wait polarity bit sets active level
package sbr_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam logic [15:0] CFG_RESET = 16'h3ddf;
  localparam int BIT_READ_MODE = 15;
  localparam int BIT_RSV14 = 14;
  localparam int LAT_LO = 11;
  localparam int LAT_HI = 13;
  localparam int BIT_WAIT_POL = 10;
  localparam int BIT_EDGE = 6;
  localparam int BIT_RSV5 = 5;
  localparam int BIT_ROLE = 4;
  localparam int BIT_WRAP = 3;
  localparam int BL_HI = 2;
  localparam logic [2:0] BL_4 = 3'h1;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [4:0] INIT_CYCLES = 5'h10;
  localparam logic [1:0] LATCH_EDGES = 2'h3;
  localparam logic [2:0] HOST_DIV = 3'h7;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam logic [1:0] REG_CFG = 2'h2;
  localparam logic [1:0] REG_DATA = 2'h3;
endpackage

// >>> hdl/sbr_link_if.sv
`timescale 1ns/100ps
// Link between flash device and host; rw pin resolved here with pull-up.
interface sbr_link_if;
  logic clk;
  logic rst_pin;
  logic ce_n;
  logic le_n;
  logic oe_n;
  logic [22:0] addr;
  logic [15:0] dq;
  logic rw_dev_o;
  logic rw_dev_oe;
  logic rw_host_o;
  logic rw_host_oe;
  logic rw_level;
  // Open pin with an external pull-up; low wins when both drive.
  assign rw_level = (rw_dev_oe ? rw_dev_o : 1'b1) & (rw_host_oe ? rw_host_o : 1'b1);
  modport dev (input clk, input rst_pin, input ce_n, input le_n, input oe_n, input addr,
    output dq, output rw_dev_o, output rw_dev_oe, input rw_level);
  modport host (output clk, output rst_pin, output ce_n, output le_n, output oe_n,
    output addr, input dq, output rw_host_o, output rw_host_oe, input rw_level);
endinterface

// >>> hdl/sbr_device.sv
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/100ps
// Flash side: burst engine on the link clock, array as a generated pattern.
module sbr_device (
  sbr_link_if.dev lnk,
  input wire logic [15:0] cfg_wdata,
  input wire logic cfg_we,
  output logic [15:0] cfg_rdata,
  output logic busy
);
  typedef enum logic [2:0] {
    SBR_INIT = 3'b000, SBR_IDLE = 3'b001, SBR_LAT = 3'b011, SBR_DATA = 3'b010,
    SBR_STALL = 3'b110, SBR_DONE = 3'b111
  } sbr_dst_t;
  sbr_dst_t st_ff, nxt_st;
  logic [15:0] cfg_ff;
  logic [4:0] init_ff;
  logic [1:0] edge_ff;
  logic [2:0] lat_ff;
  logic [1:0] wcnt_ff;
  logic [4:0] words_ff;
  logic [22:0] ad_ff;
  logic [22:0] start_ff;
  logic crossed_ff;
  logic [15:0] dq_ff;
  logic rw_s1_ff, rw_s2_ff, rw_s3_ff;
  logic [1:0] pulse_ff;
  logic rst_s1_ff, rst_s2_ff;
  // Clock used for synchronous reads; falling edge when edge bit is zero.
  // edge selection
  wire logic sel_clk = cfg_ff[sbr_pkg::BIT_EDGE] ? lnk.clk : ~lnk.clk;
  wire logic role_ready = cfg_ff[sbr_pkg::BIT_ROLE];
  wire logic sync_mode = ~cfg_ff[sbr_pkg::BIT_READ_MODE];
  wire logic [2:0] bl = cfg_ff[sbr_pkg::BL_HI:0];
  wire logic cont = (bl == sbr_pkg::BL_CONT);
  wire logic wrap = ~cfg_ff[sbr_pkg::BIT_WRAP] & ~cont;
  wire logic [4:0] blen = (bl == sbr_pkg::BL_4) ? 5'h4 : (bl == sbr_pkg::BL_8) ? 5'h8 : 5'h10;
  wire logic [22:0] gmask = {18'h0, blen - 5'h1};
  wire logic [22:0] inc = ad_ff + 23'h1;
  wire logic [22:0] nxt_addr = wrap ? ((ad_ff & ~gmask) | (inc & gmask)) : inc;
  // crossing of first 16-word boundary; not when wrapped
  wire logic at_cross = (inc[3:0] == 4'h0) & ~crossed_ff & ~wrap & (start_ff[1:0] != 2'h0);
  // The pin only gates the latch in the ready role; in wait role the device drives it.
  wire logic qual = ~lnk.ce_n & ~lnk.oe_n & (rw_s2_ff | ~role_ready);
  wire logic wait_act = (st_ff != SBR_DATA) & sync_mode;
  // high-low-high on ready pin retriggers latch sequence
  wire logic retrig = role_ready & (pulse_ff == 2'h2) & rw_s2_ff;
  // Reset pin crosses by two flops before use.
  always_ff @(posedge lnk.clk) begin
    rst_s1_ff <= lnk.rst_pin;
    rst_s2_ff <= rst_s1_ff;
    rw_s1_ff <= lnk.rw_level;
    rw_s2_ff <= rw_s1_ff;
    rw_s3_ff <= rw_s2_ff;
  end
  // Configuration writes; role bit resets to one. reserved kept zero.
  always_ff @(posedge lnk.clk) begin
    if (rst_s2_ff) begin
      cfg_ff <= sbr_pkg::CFG_RESET;
    end else if (cfg_we) begin
      cfg_ff <= cfg_wdata & ~(16'h1 << sbr_pkg::BIT_RSV14) & ~(16'h1 << sbr_pkg::BIT_RSV5);
    end
  end
  // Track levels high, low, then high on the handshake pin.
  always_ff @(posedge lnk.clk) begin
    if (rst_s2_ff | ~role_ready) begin
      pulse_ff <= 2'h0;
    end else if (retrig) begin
      pulse_ff <= 2'h0;
    end else if (pulse_ff == 2'h0 & rw_s3_ff & ~rw_s2_ff) begin
      pulse_ff <= 2'h2;
    end
  end
  // Internal configuration counter; in the ready role the pin is held low until done.
  always_ff @(posedge lnk.clk) begin
    if (rst_s2_ff) begin
      init_ff <= sbr_pkg::INIT_CYCLES;
    end else if (init_ff != 5'h0) begin
      init_ff <= init_ff - 5'h1;
    end
  end
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      SBR_INIT: if (init_ff == 5'h0) nxt_st = SBR_IDLE;
      SBR_IDLE: if (qual & lnk.le_n & (edge_ff == sbr_pkg::LATCH_EDGES - 2'h1)) nxt_st = SBR_LAT;
      SBR_LAT: if (lat_ff <= 3'h1) nxt_st = SBR_DATA;
      SBR_DATA: begin
        if (at_cross) nxt_st = SBR_STALL;
        else if (!cont && words_ff == blen - 5'h1) nxt_st = SBR_DONE;
      end
      SBR_STALL: if (wcnt_ff <= 2'h1) nxt_st = SBR_DATA;
      SBR_DONE: if (lnk.ce_n) nxt_st = SBR_IDLE;
      default: nxt_st = SBR_INIT;
    endcase
    // Deselecting the chip ends any burst, continuous ones included.
    if (lnk.ce_n && st_ff != SBR_INIT) nxt_st = SBR_IDLE;
  end
  // Burst engine on the selected edge; async mode idles the engine.
  always_ff @(posedge sel_clk) begin
    if (rst_s2_ff | retrig | init_ff != 5'h0 | ~sync_mode) begin
      st_ff <= (init_ff != 5'h0 | rst_s2_ff) ? SBR_INIT : SBR_IDLE;
      edge_ff <= 2'h0;
      crossed_ff <= 1'b0;
      words_ff <= 5'h0;
    end else begin
      st_ff <= nxt_st;
      if (st_ff == SBR_IDLE) begin
        edge_ff <= qual & lnk.le_n ? edge_ff + 2'h1 : 2'h0;
        ad_ff <= lnk.addr;
        start_ff <= lnk.addr;
        lat_ff <= cfg_ff[sbr_pkg::LAT_HI:sbr_pkg::LAT_LO];
        crossed_ff <= 1'b0;
        words_ff <= 5'h0;
      end
      if (st_ff == SBR_LAT) lat_ff <= lat_ff - 3'h1;
      if (st_ff == SBR_DATA) begin
        dq_ff <= ad_ff[15:0] ^ ad_ff[22:7];
        ad_ff <= nxt_addr;
        words_ff <= words_ff + 5'h1;
        if (at_cross) begin
          // only once; wait count equals offset
          crossed_ff <= 1'b1;
          wcnt_ff <= start_ff[1:0];
        end
      end
      if (st_ff == SBR_STALL) wcnt_ff <= wcnt_ff - 2'h1;
    end
  end
  // wait output with programmable polarity; ready low while busy.
  assign lnk.rw_dev_oe = role_ready ? (init_ff != 5'h0) : ~lnk.oe_n & ~lnk.ce_n;
  assign lnk.rw_dev_o = role_ready ? 1'b0 : (wait_act ^ ~cfg_ff[sbr_pkg::BIT_WAIT_POL]);
  assign lnk.dq = dq_ff;
  assign cfg_rdata = cfg_ff;
  assign busy = (init_ff != 5'h0);
endmodule // sbr_device

// >>> hdl/sbr_host.sv
`timescale 1ns/100ps
// Host side: register port on core_clk, link driven by a divided clock.
module sbr_host (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  sbr_link_if.host lnk
);
  logic [2:0] div_ff;
  logic clk_ff;
  logic [15:0] ctrl_ff;
  logic [22:0] addr_ff;
  logic [15:0] data_ff;
  logic [31:0] rd_ff;
  logic rw_s1_ff, rw_s2_ff;
  // Divider makes the link clock; host is the clock owner, no second domain.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_ff <= 3'h0;
      clk_ff <= 1'b0;
    end else if (div_ff == sbr_pkg::HOST_DIV) begin
      div_ff <= 3'h0;
      clk_ff <= ~clk_ff;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end
  wire logic rise = (div_ff == sbr_pkg::HOST_DIV) & ~clk_ff;
  // Control bits: 0 ce_n, 1 le_n, 2 oe_n, 3 rst, 4 pin drive enable, 5 pin level.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_ff <= 16'h000f;
      addr_ff <= 23'h0;
      data_ff <= 16'h0;
    end else begin
      if (reg_we & reg_addr == sbr_pkg::REG_CTRL) ctrl_ff <= reg_wdata[15:0];
      if (reg_we & reg_addr == sbr_pkg::REG_ADDR) addr_ff <= reg_wdata[22:0];
      if (rise & ~lnk.oe_n) data_ff <= lnk.dq;
    end
  end
  always_ff @(posedge core_clk) begin
    rw_s1_ff <= lnk.rw_level;
    rw_s2_ff <= rw_s1_ff;
  end
  // configuration is not held here; REG_CFG reads back as zero.
  wire logic [31:0] rd_mux = (reg_addr == sbr_pkg::REG_CTRL) ? {15'h0, rw_s2_ff, ctrl_ff} :
    (reg_addr == sbr_pkg::REG_ADDR) ? {9'h0, addr_ff} :
    (reg_addr == sbr_pkg::REG_DATA) ? {16'h0, data_ff} : 32'h0;
  always_ff @(posedge core_clk) begin
    if (reset) rd_ff <= 32'h0;
    else if (reg_re) rd_ff <= rd_mux;
  end
  assign reg_rdata = rd_ff;
  assign lnk.clk = clk_ff;
  assign lnk.ce_n = ctrl_ff[0];
  assign lnk.le_n = ctrl_ff[1];
  assign lnk.oe_n = ctrl_ff[2];
  assign lnk.rst_pin = ctrl_ff[3];
  assign lnk.addr = addr_ff;
  // host may pulse the ready pin to restart the latch sequence.
  assign lnk.rw_host_oe = ctrl_ff[4];
  assign lnk.rw_host_o = ctrl_ff[5];
endmodule // sbr_host

// >>> testbench/sbr_link_assertions.sv
`timescale 1ns/100ps
// Watches the link and the device side of the configuration register.
module sbr_link_assertions (
  input wire logic clk,
  input wire logic rst_pin,
  input wire logic ce_n,
  input wire logic le_n,
  input wire logic oe_n,
  input wire logic [22:0] addr,
  input wire logic [15:0] dq,
  input wire logic rw_dev_o,
  input wire logic rw_dev_oe,
  input wire logic rw_level,
  input wire logic [15:0] cfg_rdata,
  input wire logic busy
);
  // A qualified edge needs the shared pin released high; in the ready role the device does not latch otherwise.
  wire q = !ce_n && !oe_n && le_n && rw_level;
  wire rdy = cfg_rdata[4];
  default clocking @(posedge clk); endclocking
  default disable iff (rst_pin);
  sequence s_latch;
    $rose(q) ##1 q [*2] ##0 cfg_rdata[13:11] == 3'h7;
  endsequence
  chk_busy_pin_low: assert property (
    busy && rdy |-> rw_dev_oe && !rw_dev_o) else $error("pin not low while busy");
  chk_busy_holds: assert property (
    $fell(rst_pin) |-> ##4 busy [*8]) else $error("busy dropped too soon");
  chk_busy_ends: assert property (
    $fell(rst_pin) |-> ##[1:40] !busy) else $error("busy never ended");
  chk_cfg_default: assert property (
    $fell(rst_pin) |-> ##12 cfg_rdata == sbr_pkg::CFG_RESET) else $error("bad cfg default");
  chk_ready_open: assert property (
    rdy |-> !(rw_dev_oe && rw_dev_o)) else $error("ready pin driven high");
  chk_wait_drives: assert property (
    !busy && !rdy && !ce_n && !oe_n |-> rw_dev_oe) else $error("wait pin not driven");
  chk_first_word: assert property (
    s_latch |-> ##[4:10] dq == (addr[15:0] ^ addr[22:7])) else $error("first word late");
  chk_pin_release: assert property (
    $fell(busy) && rdy |-> ##[0:2] !rw_dev_oe) else $error("pin kept after init");
endmodule // sbr_link_assertions

// >>> testbench/sync_burst_read_config_bench.sv
`timescale 1ns/100ps
// Drives the host register port and the device config port.
module sync_burst_read_config_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] cfg_wdata = 16'h0;
  logic cfg_we = 1'b0;
  logic [15:0] cfg_rdata;
  logic busy;
  logic [15:0] c;
  logic [22:0] a;
  logic [2:0] lat;
  logic [22:0] m;
  logic [22:0] e;
  logic [2:0] bl [4] = '{sbr_pkg::BL_4, sbr_pkg::BL_8, sbr_pkg::BL_16, sbr_pkg::BL_CONT};
  logic [31:0] exp_q [$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  sbr_link_if lnk ();
  sbr_host sbr_host_i (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .lnk(lnk));
  sbr_device sbr_device_i (.lnk(lnk), .cfg_wdata, .cfg_we, .cfg_rdata, .busy);
  sbr_link_assertions sbr_link_assertions_i (.clk(lnk.clk), .rst_pin(lnk.rst_pin),
    .ce_n(lnk.ce_n), .le_n(lnk.le_n), .oe_n(lnk.oe_n), .addr(lnk.addr), .dq(lnk.dq),
    .rw_dev_o(lnk.rw_dev_o), .rw_dev_oe(lnk.rw_dev_oe), .rw_level(lnk.rw_level),
    .cfg_rdata, .busy);
  always #2.5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Strobes drop for one cycle between accesses so no edge sees two drives.
  task automatic acc(input logic w, input logic [1:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_we <= w;
    reg_re <= !w;
    @(posedge core_clk);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic cw(input logic [15:0] v);
    @(posedge lnk.clk);
    cfg_wdata <= v;
    cfg_we <= 1'b1;
    @(posedge lnk.clk);
    cfg_we <= 1'b0;
  endtask
  task automatic wait_idle();
    repeat (600) begin
      if (busy === 1'b0) break;
      @(posedge core_clk);
    end
    check(32'(busy), 32'h0);
  endtask
  // Read data stands from the cycle after the strobe until the next read.
  always @(posedge core_clk) begin
    rd_d <= reg_re;
    if (rd_d) check(reg_rdata, exp_q.pop_front());
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(53403));
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    // The host holds the reset pin after its own reset; give the link clock time.
    repeat (64) @(posedge core_clk);
    acc(1'b1, sbr_pkg::REG_CTRL, 32'h7);
    wait_idle();
    check({16'h0, cfg_rdata}, {16'h0, sbr_pkg::CFG_RESET});
    exp_q.push_back(32'h0);
    acc(1'b0, sbr_pkg::REG_CFG, 32'h0);
    // Every latency, both edges, both roles and polarities, all burst codes.
    for (int i = 0; i < 12; i++) begin
      lat = 3'(2 + i % 6);
      a = 23'($urandom());
      // reserved bits zero, documented burst codes only.
      c = {2'h0, lat, i[1], sbr_pkg::CFG_RESET[9:7], i < 6, 1'b0, i[0], i[2], bl[i % 4]};
      cw(c);
      acc(1'b1, sbr_pkg::REG_ADDR, {9'h0, a});
      acc(1'b1, sbr_pkg::REG_CTRL, 32'h2);
      // Long enough for latch, latency, stall and sixteen words.
      repeat (48) @(posedge lnk.clk);
      // A fixed burst parks on its last word, known from start, length and wrap.
      m = 23'((5'h4 << (i % 4)) - 5'h1);
      e = c[3] ? a + m : (a & ~m) | ((a + m) & m);
      if (bl[i % 4] != sbr_pkg::BL_CONT) exp_q.push_back({16'h0, e[15:0] ^ e[22:7]});
      if (bl[i % 4] != sbr_pkg::BL_CONT) acc(1'b0, sbr_pkg::REG_DATA, 32'h0);
      acc(1'b1, sbr_pkg::REG_CTRL, 32'h7);
      $display("burst test %0d done", i);
    end
    // A reset pulse in mid-run must bring back busy and the default config.
    acc(1'b1, sbr_pkg::REG_CTRL, 32'hf);
    repeat (64) @(posedge core_clk);
    acc(1'b1, sbr_pkg::REG_CTRL, 32'h7);
    check(32'(busy), 32'h1);
    wait_idle();
    check({16'h0, cfg_rdata}, {16'h0, sbr_pkg::CFG_RESET});
    $display("reset test done");
    repeat (4) @(posedge core_clk);
    end_sim();
  end
endmodule // sync_burst_read_config_bench
